//--- hw/rro_pkg.sv
// Constants and types for the relative reference offset block
package rro_pkg;

   localparam int         RRO_NFUNC     = 10;
   localparam logic [3:0] RRO_LAST_FUNC = 4'h9;

   // Register byte offsets
   localparam logic [7:0] RRO_OFS_CMD    = 8'h00;
   localparam logic [7:0] RRO_OFS_ARG    = 8'h04;
   localparam logic [7:0] RRO_OFS_QSEL   = 8'h08;
   localparam logic [7:0] RRO_OFS_QDATA  = 8'h0c;
   localparam logic [7:0] RRO_OFS_STATUS = 8'h10;
   localparam logic [7:0] RRO_OFS_MASK   = 8'h14;
   localparam logic [7:0] RRO_OFS_STATE  = 8'h18;

   // Reset values
   localparam logic signed [31:0] RRO_REF_RESET  = 32'sh0000_0000;
   localparam logic signed [31:0] RRO_ARG_RESET  = 32'sh0000_0000;

   // Status register fields
   localparam int RRO_EV_W         = 5;
   localparam int RRO_EV_WRONG_FN  = 0;
   localparam int RRO_EV_OVERFLOW  = 1;
   localparam int RRO_EV_NO_READ   = 2;
   localparam int RRO_EV_RANGE     = 3;
   localparam int RRO_EV_CHANGED   = 4;
   localparam logic [RRO_EV_W-1:0] RRO_MASK_RESET = 5'h00;

   // State register fields
   localparam int RRO_ST_FUNC_LSB  = 16;
   localparam int RRO_ST_HAVE_READ = 20;
   localparam int RRO_ST_LAST_OVF  = 21;

   // Limits; current in uA, voltage in mV, ohms, Hz, us, milli-degrees
   localparam logic signed [31:0] RRO_CUR_MIN  = 32'shffd0_b2a0;
   localparam logic signed [31:0] RRO_CUR_MAX  = 32'sh002f_4d60;
   localparam logic signed [31:0] RRO_ACV_MIN  = 32'shfff4_7104;
   localparam logic signed [31:0] RRO_ACV_MAX  = 32'sh000b_8efc;
   localparam logic signed [31:0] RRO_DCV_MIN  = 32'shfff0_96b0;
   localparam logic signed [31:0] RRO_DCV_MAX  = 32'sh000f_6950;
   localparam logic signed [31:0] RRO_SNS_MIN  = 32'shffff_d88c;
   localparam logic signed [31:0] RRO_SNS_MAX  = 32'sh0000_2774;
   localparam logic signed [31:0] RRO_RES_MAX  = 32'sh0727_0e00;
   localparam logic signed [31:0] RRO_FRQ_MAX  = 32'sh00e4_e1c0;
   localparam logic signed [31:0] RRO_PER_MAX  = 32'sh000f_4240;
   localparam logic signed [31:0] RRO_TMP_MIN  = 32'shfffc_f2c0;
   localparam logic signed [31:0] RRO_TMP_MAX  = 32'sh0014_ef60;
   localparam logic signed [31:0] RRO_ZERO     = 32'sh0000_0000;

   typedef enum logic [3:0] {
      RRO_FN_AC_CURRENT,
      RRO_FN_DC_CURRENT,
      RRO_FN_AC_VOLTAGE,
      RRO_FN_DC_VOLTAGE,
      RRO_FN_RES_2WIRE,
      RRO_FN_RES_4WIRE,
      RRO_FN_CYCLE_RATE,
      RRO_FN_CYCLE_LENGTH,
      RRO_FN_THERMAL,
      RRO_FN_SENSE_INPUT
   } rro_func_t;

   typedef enum logic [2:0] {
      RRO_OP_SET_VALUE,
      RRO_OP_SET_MIN,
      RRO_OP_SET_MAX,
      RRO_OP_SET_DEFAULT,
      RRO_OP_ACQUIRE,
      RRO_OP_STATE_ON,
      RRO_OP_STATE_OFF
   } rro_op_t;

   typedef enum logic [2:0] {
      RRO_Q_PLAIN,
      RRO_Q_DEFAULT,
      RRO_Q_MIN,
      RRO_Q_MAX,
      RRO_Q_STATE
   } rro_form_t;

   // Command word: op in [6:4], function in [3:0]
   typedef struct packed {
      logic [2:0] op;
      logic [3:0] func;
   } rro_cmd_t;

   typedef struct packed {
      logic                valid;
      logic                overflow;
      logic signed [31:0]  value;
   } rro_meas_t;

endpackage : rro_pkg

//--- hw/rro_limits.sv
// Allowed reference range lookup per measurement function
`timescale 1ns/1ns
`default_nettype none
module rro_limits
   import rro_pkg::*;
(
   input  wire logic [3:0]         func,
   output logic signed [31:0]      lim_min,
   output logic signed [31:0]      lim_max
);

   always_comb begin
      lim_min = RRO_ZERO;
      lim_max = RRO_ZERO;
      case (func)
         RRO_FN_AC_CURRENT, RRO_FN_DC_CURRENT: begin
            lim_min = RRO_CUR_MIN;
            lim_max = RRO_CUR_MAX;
         end
         RRO_FN_AC_VOLTAGE: begin
            lim_min = RRO_ACV_MIN;
            lim_max = RRO_ACV_MAX;
         end
         RRO_FN_DC_VOLTAGE: begin
            lim_min = RRO_DCV_MIN;
            lim_max = RRO_DCV_MAX;
         end
         RRO_FN_SENSE_INPUT: begin
            lim_min = RRO_SNS_MIN;
            lim_max = RRO_SNS_MAX;
         end
         RRO_FN_RES_2WIRE, RRO_FN_RES_4WIRE: lim_max = RRO_RES_MAX;
         RRO_FN_CYCLE_RATE: lim_max = RRO_FRQ_MAX;
         RRO_FN_CYCLE_LENGTH: lim_max = RRO_PER_MAX;
         RRO_FN_THERMAL: begin
            lim_min = RRO_TMP_MIN;
            lim_max = RRO_TMP_MAX;
         end
         default: begin
            lim_min = RRO_ZERO;
            lim_max = RRO_ZERO;
         end
      endcase
   end

endmodule : rro_limits
`default_nettype wire

//--- hw/rro_irq.sv
// Sticky event status with write-one-to-clear, mask and level interrupt
`timescale 1ns/1ns
`default_nettype none
module rro_irq
   import rro_pkg::*;
(
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic [RRO_EV_W-1:0] event_set,
   input  wire logic                clear_we,
   input  wire logic                mask_we,
   input  wire logic [RRO_EV_W-1:0] wdata,
   output logic [RRO_EV_W-1:0]      status,
   output logic [RRO_EV_W-1:0]      mask,
   output logic                     irq
);

   // A new event in the clearing cycle survives
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= '0;
      end else begin
         status <= (status & ~(clear_we ? wdata : '0)) | event_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask <= RRO_MASK_RESET;
      end else if (mask_we) begin
         mask <= wdata;
      end
   end

   assign irq = |(status & mask);

endmodule : rro_irq
`default_nettype wire

//--- hw/rro_top.sv
// Relative reference offset block with APB register access
`timescale 1ns/1ns
`default_nettype none
module rro_top
   import rro_pkg::*;
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire rro_meas_t          meas,
   input  wire logic [3:0]         active_function,
   output rro_meas_t               reading,
   output logic                    relative_display,
   output logic                    irq
);

   logic signed [31:0]       ref_value [RRO_NFUNC];
   logic [RRO_NFUNC-1:0]     ref_enable;
   logic signed [31:0]       arg;
   rro_cmd_t                 qsel;
   logic signed [31:0]       last_meas;
   logic                     last_overflow;
   logic                     have_reading;
   logic [3:0]               prev_function;

   logic                     setup;
   logic                     wr;
   rro_cmd_t                 cmd;
   logic                     cmd_legal;
   logic                     qsel_legal;
   logic                     cmd_go;
   logic signed [31:0]       cmd_min;
   logic signed [31:0]       cmd_max;
   logic signed [31:0]       q_min;
   logic signed [31:0]       q_max;
   logic                     ref_we;
   logic signed [31:0]       next_ref;
   logic                     en_set;
   logic                     en_clr;
   logic [RRO_EV_W-1:0]      events;
   logic [RRO_EV_W-1:0]      status;
   logic [RRO_EV_W-1:0]      mask;
   logic [31:0]              next_prdata;
   logic                     next_pslverr;
   logic [31:0]              qdata;
   logic                     active_legal;
   logic signed [31:0]       active_ref;
   logic                     active_en;

   // Bus phases; the slave never inserts wait states
   assign setup  = psel & ~penable;
   assign wr     = psel & penable & pwrite;
   assign pready = 1'b1;

   assign cmd        = rro_cmd_t'(pwdata[6:0]);
   assign qsel_legal = (pwdata[3:0] <= RRO_LAST_FUNC) && (pwdata[6:4] <= RRO_Q_STATE);
   assign cmd_legal  = (cmd.func <= RRO_LAST_FUNC) && (cmd.op <= RRO_OP_STATE_OFF);
   assign cmd_go     = wr && (paddr == RRO_OFS_CMD) && cmd_legal;

   rro_limits u_cmd_limits (
      .func    (cmd.func),
      .lim_min (cmd_min),
      .lim_max (cmd_max)
   );

   rro_limits u_qry_limits (
      .func    (qsel.func),
      .lim_min (q_min),
      .lim_max (q_max)
   );

   // Command execution; every writer of the reference goes through next_ref
   always_comb begin
      ref_we   = 1'b0;
      next_ref = RRO_REF_RESET;
      en_set   = 1'b0;
      en_clr   = 1'b0;
      events   = '0;
      if (cmd_go) begin
         case (rro_op_t'(cmd.op))
            RRO_OP_SET_VALUE: begin
               if (arg < cmd_min || arg > cmd_max) begin
                  events[RRO_EV_RANGE] = 1'b1;
               end else begin
                  ref_we   = 1'b1;
                  next_ref = arg;
               end
            end
            RRO_OP_SET_MIN: begin
               ref_we   = 1'b1;
               next_ref = cmd_min;
            end
            RRO_OP_SET_MAX: begin
               ref_we   = 1'b1;
               next_ref = cmd_max;
            end
            RRO_OP_SET_DEFAULT: begin
               ref_we   = 1'b1;
               next_ref = RRO_REF_RESET;
            end
            RRO_OP_ACQUIRE: begin
               if (cmd.func != active_function) begin
                  events[RRO_EV_WRONG_FN] = 1'b1;
               end else if (!have_reading) begin
                  events[RRO_EV_NO_READ] = 1'b1;
               end else if (last_overflow) begin
                  events[RRO_EV_OVERFLOW] = 1'b1;
               end else begin
                  ref_we   = 1'b1;
                  next_ref = last_meas;
               end
            end
            RRO_OP_STATE_ON:  en_set = 1'b1;
            RRO_OP_STATE_OFF: en_clr = 1'b1;
            default: begin
               ref_we = 1'b0;
            end
         endcase
      end
      events[RRO_EV_CHANGED] = ref_we;
   end

   // Per-function reference and enable storage
   for (genvar i = 0; i < RRO_NFUNC; i++) begin : g_func
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ref_value[i] <= RRO_REF_RESET;
         end else if (cmd_go && ref_we && cmd.func == 4'(i)) begin
            ref_value[i] <= next_ref;
         end
      end

      // Enable flags follow the on and off commands only
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ref_enable[i] <= 1'b0;
         end else if (cmd_go && en_set && cmd.func == 4'(i)) begin
            ref_enable[i] <= 1'b1;
         end else if (cmd_go && en_clr && cmd.func == 4'(i)) begin
            ref_enable[i] <= 1'b0;
         end
      end
   end

   // Numeric argument and query selection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arg <= RRO_ARG_RESET;
      end else if (wr && paddr == RRO_OFS_ARG) begin
         arg <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qsel <= '0;
      end else if (wr && paddr == RRO_OFS_QSEL && qsel_legal) begin
         qsel <= rro_cmd_t'(pwdata[6:0]);
      end
   end

   // Raw measurement tracking for capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_meas <= RRO_REF_RESET;
      end else if (meas.valid) begin
         last_meas <= meas.value;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_overflow <= 1'b0;
      end else if (meas.valid) begin
         last_overflow <= meas.overflow;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_function <= 4'h0;
      end else begin
         prev_function <= active_function;
      end
   end

   // A new function selection forgets earlier readings; a reading in the same cycle counts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         have_reading <= 1'b0;
      end else if (meas.valid) begin
         have_reading <= 1'b1;
      end else if (active_function != prev_function) begin
         have_reading <= 1'b0;
      end
   end

   // Relative reading path
   assign active_legal = (active_function <= RRO_LAST_FUNC);
   assign active_ref   = active_legal ? ref_value[active_function] : RRO_REF_RESET;
   assign active_en    = active_legal && ref_enable[active_function];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reading <= '0;
      end else begin
         reading.valid <= meas.valid;
         if (meas.valid) begin
            reading.overflow <= meas.overflow;
            if (active_en && !meas.overflow) begin
               reading.value <= meas.value - active_ref;
            end else begin
               reading.value <= meas.value;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         relative_display <= 1'b0;
      end else begin
         relative_display <= active_en;
      end
   end

   rro_irq u_irq (
      .pclk      (pclk),
      .presetn   (presetn),
      .event_set (events),
      .clear_we  (wr && paddr == RRO_OFS_STATUS),
      .mask_we   (wr && paddr == RRO_OFS_MASK),
      .wdata     (pwdata[RRO_EV_W-1:0]),
      .status    (status),
      .mask      (mask),
      .irq       (irq)
   );

   // Query answers
   always_comb begin
      qdata = 32'h0000_0000;
      case (rro_form_t'(qsel.op))
         RRO_Q_PLAIN:   qdata = ref_value[qsel.func];
         RRO_Q_DEFAULT: qdata = RRO_REF_RESET;
         RRO_Q_MIN:     qdata = q_min;
         RRO_Q_MAX:     qdata = q_max;
         RRO_Q_STATE:   qdata = {31'h0000_0000, ref_enable[qsel.func]};
         default:       qdata = 32'h0000_0000;
      endcase
   end

   // Read data and error are prepared in the setup phase
   always_comb begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      case (paddr)
         RRO_OFS_CMD:    next_pslverr = pwrite && !cmd_legal;
         RRO_OFS_ARG:    next_prdata = arg;
         RRO_OFS_QSEL:   begin
            next_prdata  = {25'h000_0000, qsel};
            next_pslverr = pwrite && !qsel_legal;
         end
         RRO_OFS_QDATA:  next_prdata = qdata;
         RRO_OFS_STATUS: next_prdata = {27'h000_0000, status};
         RRO_OFS_MASK:   next_prdata = {27'h000_0000, mask};
         RRO_OFS_STATE:  begin
            next_prdata[RRO_NFUNC-1:0]                     = ref_enable;
            next_prdata[RRO_ST_FUNC_LSB+3:RRO_ST_FUNC_LSB] = active_function;
            next_prdata[RRO_ST_HAVE_READ]                  = have_reading;
            next_prdata[RRO_ST_LAST_OVF]                   = last_overflow;
         end
         default:        next_pslverr = 1'b1;
      endcase
      if (pwrite) begin
         next_prdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= setup ? next_prdata : 32'h0000_0000;
      end
   end

   // Error flag stands in the access cycle only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= setup & next_pslverr;
      end
   end

endmodule : rro_top
`default_nettype wire

//--- bench/rro_checker.sv
// Concurrent checks on the ports of the relative reference offset block
`timescale 1ns/1ns
`default_nettype none
module rro_checker
   import rro_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire rro_meas_t   meas,
   input  wire logic [3:0]  active_function,
   input  wire rro_meas_t   reading,
   input  wire logic        relative_display
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_access;
      psel && penable;
   endsequence
   // A reading taken while subtraction is known to be off for the active function
   sequence s_plain_raw;
      meas.valid && !relative_display && $stable(active_function)
         && !$past(psel && penable && pwrite);
   endsequence
   a_reading_pulse: assert property (meas.valid |=> reading.valid)
      else $error("reading pulse missing");
   a_no_extra: assert property (!meas.valid |=> !reading.valid)
      else $error("reading pulse without measurement");
   a_hold_value: assert property (!meas.valid |=> $stable(reading.value))
      else $error("reading value moved between readings");
   a_ovf_follow: assert property (meas.valid |=> reading.overflow == $past(meas.overflow))
      else $error("overflow flag not carried");
   a_pass_off: assert property (s_plain_raw |=> reading.value == $past(meas.value))
      else $error("reading altered while subtraction off");
   a_ovf_raw: assert property (meas.valid && meas.overflow |=> reading.value == $past(meas.value))
      else $error("overflowed reading altered");
   a_err_access: assert property (pslverr |-> s_access)
      else $error("error outside access phase");
   a_unmapped_err: assert property (s_access ##0 paddr > 8'h18 |-> pslverr)
      else $error("unmapped access not refused");
   a_idle_rdata: assert property (!(psel && penable) |-> prdata == 32'h0 && pready)
      else $error("read data outside access phase");
endmodule : rro_checker
bind rro_top rro_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .meas, .active_function, .reading, .relative_display);
`default_nettype wire

//--- bench/rro_engine_model.sv
// Measurement engine model: one-cycle reading pulses and the selected function
`timescale 1ns/1ns
`default_nettype none
module rro_engine_model
   import rro_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        fire,
   input  wire logic        ovf,
   input  wire logic [31:0] val,
   input  wire logic [3:0]  fn,
   output rro_meas_t        meas,
   output logic [3:0]       active_function
);
   initial meas = '0;
   initial active_function = 4'h0;
   // Value lines toggle between readings so stale data is never mistaken for valid
   always @(posedge pclk) begin
      active_function <= fn;
      meas.valid <= fire;
      meas.overflow <= ovf;
      meas.value <= fire ? val : ~meas.value;
   end
endmodule : rro_engine_model
`default_nettype wire

//--- bench/rro_top_tb.sv
// Self-checking bench for the relative reference offset block
`timescale 1ns/1ns
`default_nettype none
module rro_top_tb
   import rro_pkg::*;
;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = '0;
   logic [31:0] pwdata = '0, prdata, rv, val = '0;
   logic        pready, pslverr, relative_display, irq, re, fire = 0, ovf = 0;
   logic [3:0]  fn_q = '0, active_function;
   rro_meas_t   meas, reading;
   int          n_fail = 0, checks = 0;
   logic [31:0] lo [10] = '{RRO_CUR_MIN, RRO_CUR_MIN, RRO_ACV_MIN, RRO_DCV_MIN, RRO_ZERO,
                            RRO_ZERO, RRO_ZERO, RRO_ZERO, RRO_TMP_MIN, RRO_SNS_MIN};
   logic [31:0] hi [10] = '{RRO_CUR_MAX, RRO_CUR_MAX, RRO_ACV_MAX, RRO_DCV_MAX, RRO_RES_MAX,
                            RRO_RES_MAX, RRO_FRQ_MAX, RRO_PER_MAX, RRO_TMP_MAX, RRO_SNS_MAX};
   always #4 pclk = ~pclk;
   rro_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .meas, .active_function, .reading, .relative_display, .irq);
   rro_engine_model u_eng (.pclk, .fire, .ovf, .val, .fn(fn_q), .meas, .active_function);
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Request stands until pready is seen high at a rising edge
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rv = prdata;
      re = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic cmd(input logic [2:0] op, input logic [3:0] f);
      apb(1'b1, RRO_OFS_CMD, {25'h0, op, f});
   endtask : cmd
   task automatic q(input logic [3:0] f, input logic [2:0] fm, input logic [31:0] e);
      apb(1'b1, RRO_OFS_QSEL, {25'h0, fm, f});
      apb(1'b0, RRO_OFS_QDATA, '0);
      chk("qdata", e, rv);
   endtask : q
   task automatic stat(input logic [4:0] e, input logic i);
      apb(1'b0, RRO_OFS_STATUS, '0);
      chk("status", {27'h0, e}, rv);
      chk("irq", {31'h0, i}, {31'h0, irq});
      apb(1'b1, RRO_OFS_STATUS, 32'h1f);
   endtask : stat
   task automatic shot(input logic [31:0] v, input logic o, input logic [31:0] e);
      @(posedge pclk);
      fire <= 1'b1;
      val  <= v;
      ovf  <= o;
      @(posedge pclk);
      fire <= 1'b0;
      repeat (4) begin
         @(negedge pclk);
         if (reading.valid === 1'b1) break;
      end
      chk("reading valid", 32'h1, {31'h0, reading.valid});
      chk("reading", e, reading.value);
   endtask : shot
   task automatic t_reset();
      for (int f = 0; f < 10; f++) begin
         q(f[3:0], RRO_Q_PLAIN, 32'h0);
         q(f[3:0], RRO_Q_DEFAULT, 32'h0);
      end
   endtask : t_reset
   task automatic t_limits();
      for (int f = 0; f < 10; f++) begin
         q(f[3:0], RRO_Q_MIN, lo[f]);
         q(f[3:0], RRO_Q_MAX, hi[f]);
         cmd(RRO_OP_SET_MAX, f[3:0]);
         q(f[3:0], RRO_Q_PLAIN, hi[f]);
         cmd(RRO_OP_SET_MIN, f[3:0]);
         q(f[3:0], RRO_Q_PLAIN, lo[f]);
         cmd(RRO_OP_SET_DEFAULT, f[3:0]);
         q(f[3:0], RRO_Q_PLAIN, 32'h0);
      end
      apb(1'b1, RRO_OFS_MASK, 32'h1f);
      stat(5'h10, 1'b1);
   endtask : t_limits
   task automatic t_range();
      apb(1'b1, RRO_OFS_ARG, RRO_DCV_MAX);
      cmd(RRO_OP_SET_VALUE, 4'h3);
      q(4'h3, RRO_Q_PLAIN, RRO_DCV_MAX);
      apb(1'b1, RRO_OFS_ARG, RRO_DCV_MAX + 32'h1);
      cmd(RRO_OP_SET_VALUE, 4'h3);
      chk("pslverr", 32'h0, {31'h0, re});
      q(4'h3, RRO_Q_PLAIN, RRO_DCV_MAX);
      stat(5'h18, 1'b1);
   endtask : t_range
   task automatic t_sub();
      apb(1'b1, RRO_OFS_ARG, 32'h3e8);
      cmd(RRO_OP_SET_VALUE, 4'h3);
      @(posedge pclk) fn_q <= 4'h3;
      cmd(RRO_OP_STATE_ON, 4'h3);
      q(4'h3, RRO_Q_STATE, 32'h1);
      q(4'h2, RRO_Q_STATE, 32'h0);
      shot(32'd5000, 1'b0, 32'd4000);
      chk("display", 32'h1, {31'h0, relative_display});
      shot(32'hfffffffb, 1'b1, 32'hfffffffb);
      cmd(RRO_OP_STATE_OFF, 4'h3);
      q(4'h3, RRO_Q_STATE, 32'h0);
      shot(32'd5000, 1'b0, 32'd5000);
      q(4'h3, RRO_Q_PLAIN, 32'h3e8);
      stat(5'h10, 1'b1);
   endtask : t_sub
   task automatic t_acq();
      @(posedge pclk) fn_q <= 4'h2;
      repeat (3) @(posedge pclk);
      cmd(RRO_OP_ACQUIRE, 4'h2);
      stat(5'h04, 1'b1);
      @(negedge pclk);
      chk("irq", 32'h0, {31'h0, irq});
      shot(32'd777, 1'b0, 32'd777);
      cmd(RRO_OP_ACQUIRE, 4'h3);
      stat(5'h01, 1'b1);
      q(4'h3, RRO_Q_PLAIN, 32'h3e8);
      cmd(RRO_OP_ACQUIRE, 4'h2);
      q(4'h2, RRO_Q_PLAIN, 32'd777);
      apb(1'b1, RRO_OFS_ARG, 32'h5);
      cmd(RRO_OP_SET_VALUE, 4'h2);
      q(4'h2, RRO_Q_PLAIN, 32'h5);
      shot(32'd9, 1'b1, 32'd9);
      apb(1'b1, RRO_OFS_MASK, 32'h0);
      cmd(RRO_OP_ACQUIRE, 4'h2);
      q(4'h2, RRO_Q_PLAIN, 32'h5);
      stat(5'h12, 1'b0);
      apb(1'b0, RRO_OFS_STATE, '0);
      chk("state", 32'h0032_0000, rv);
      apb(1'b0, 8'h40, '0);
      chk("pslverr", 32'h1, {31'h0, re});
   endtask : t_acq
   task automatic results();
      $display("checks %0d, mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      results();
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_limits();
      t_range();
      t_sub();
      t_acq();
      results();
   end
endmodule : rro_top_tb
`default_nettype wire
